/* File: test/cpu_or_shift_move_indirect_ops_tb.sv */
// Self-checking bench of the operation unit through its register bus.
// Assumes the register map of ocmi_map.svh; clock enable high except in one freeze test.
`timescale 1ns/1ps
`include "ocmi_map.svh"

module cpu_or_shift_move_indirect_ops_tb;
  import ocmi_pkg::*;
  logic            core_clk_i = 1'b0;
  logic            rst_b_i    = 1'b0;
  logic            ce_i       = 1'b1;
  ocmi_wb_req_type wb_req     = '0;
  logic            wb_ack;
  logic [31:0]     wb_dat;
  logic [7:0]      w;
  ocmi_flags_type  flags;
  logic [31:0]     rd;
  logic [7:0]      pat [3] = '{8'hA1, 8'hB2, 8'hC3};
  int              err_count  = 0;
  int              n_checks   = 0;
  int              cycles     = 0;
  int              ea;
  int              fin;

  always #12.5 core_clk_i = ~core_clk_i;

  ocmi_core u_dut
  (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .wb_req_i   (wb_req),
    .wb_ack_o   (wb_ack),
    .wb_dat_o   (wb_dat),
    .w_o        (w),
    .flags_o    (flags)
  );

  // ==========================================================================
  // Report, compare and bus tasks
  task finish_test;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task wb(input logic we, input logic [11:0] adr, input logic [31:0] dat);
    @(posedge core_clk_i);
    wb_req <= '{1'b1, 1'b1, we, adr, 4'hF, dat};
    do @(posedge core_clk_i);
    while (wb_ack !== 1'b1);
    rd = wb_dat;
    wb_req <= '0;
  endtask

  task rdc(input logic [11:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h00000000);
    check(rd, exp);
  endtask

  task op(input logic [2:0] o, input logic d, input logic i, input logic [1:0] m, input logic r,
          input logic [6:0] f, input logic [5:0] k);
    wb(1'b1, `OCMI_OFF_CMD, {10'h000, k, 1'b0, f, r, m, i, d, o});
  endtask

  task mw(input int i, input logic [7:0] v);
    wb(1'b1, 12'h400 + 12'(i * 4), {24'h000000, v});
  endtask

  task mc(input int i, input logic [7:0] v);
    rdc(12'h400 + 12'(i * 4), {24'h000000, v});
  endtask

  task wc(input logic [7:0] v);
    rdc(`OCMI_OFF_W, {24'h000000, v});
  endtask

  task stc(input logic z, input logic c);
    rdc(`OCMI_OFF_STATUS, {30'h0, z, c});
  endtask

  // Hang guard
  always @(posedge core_clk_i)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      err_count++;
      finish_test();
    end
  end

  // ==========================================================================
  // Test sequence
  initial
  begin
    repeat (10) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    wc(8'h00);
    stc(1'b0, 1'b0);
    rdc(`OCMI_OFF_FSR0, 32'h00000000);
    rdc(`OCMI_OFF_FSR1, 32'h00000000);
    rdc(12'h020, 32'h00000000);
    // OR to file and to W
    wb(1'b1, `OCMI_OFF_W, 32'h00000050);
    mw(10, 8'h0A);
    op(3'h0, 1'b1, 1'b0, 2'h0, 1'b0, 7'd10, 6'h00);
    mc(10, 8'h5A);
    wc(8'h50);
    stc(1'b0, 1'b0);
    wb(1'b1, `OCMI_OFF_W, 32'h00000000);
    mw(12, 8'h00);
    op(3'h0, 1'b0, 1'b0, 2'h0, 1'b0, 7'd12, 6'h00);
    stc(1'b1, 1'b0);
    // Shifts
    mw(20, 8'h81);
    op(3'h1, 1'b0, 1'b0, 2'h0, 1'b0, 7'd20, 6'h00);
    wc(8'h02);
    stc(1'b0, 1'b1);
    mc(20, 8'h81);
    mw(21, 8'h80);
    op(3'h1, 1'b1, 1'b0, 2'h0, 1'b0, 7'd21, 6'h00);
    mc(21, 8'h00);
    stc(1'b1, 1'b1);
    mw(22, 8'h01);
    op(3'h2, 1'b1, 1'b0, 2'h0, 1'b0, 7'd22, 6'h00);
    mc(22, 8'h00);
    stc(1'b1, 1'b1);
    mw(23, 8'hFE);
    op(3'h2, 1'b0, 1'b0, 2'h0, 1'b0, 7'd23, 6'h00);
    wc({1'b0, 7'h7F});
    stc(1'b0, 1'b0);
    // Move as zero test, carry kept
    wb(1'b1, `OCMI_OFF_STATUS, 32'h00000001);
    mw(24, 8'h00);
    op(3'h3, 1'b1, 1'b0, 2'h0, 1'b0, 7'd24, 6'h00);
    mc(24, 8'h00);
    stc(1'b1, 1'b1);
    wb(1'b1, `OCMI_OFF_W, 32'h00000033);
    mw(25, 8'h80);
    op(3'h3, 1'b0, 1'b0, 2'h0, 1'b0, 7'd25, 6'h00);
    wc(8'h80);
    stc(1'b0, 1'b1);
    // Indirect load, every pointer mode
    mw(47, pat[0]);
    mw(48, pat[1]);
    mw(49, pat[2]);
    for (int m = 0; m < 4; m++)
    begin
      fin = (m % 2 == 1) ? 47 : 49;
      ea = (m >= 2) ? 48 : fin;
      wb(1'b1, `OCMI_OFF_FSR0, 32'h00000030);
      op(3'h4, 1'b1, 1'b0, 2'(m), 1'b0, 7'd0, 6'h00);
      wc(pat[ea - 47]);
      rdc(`OCMI_OFF_FSR0, 32'(fin));
    end
    // Relative offsets at both bounds
    wb(1'b1, `OCMI_OFF_FSR1, 32'h00000050);
    mw(111, 8'h6E);
    op(3'h4, 1'b0, 1'b1, 2'h0, 1'b1, 7'd0, 6'h20);
    wc(pat[1]);
    op(3'h4, 1'b0, 1'b1, 2'h0, 1'b1, 7'd0, 6'h1F);
    wc(8'h6E);
    rdc(`OCMI_OFF_FSR1, 32'h00000050);
    // Pointer wrap both ways
    mw(0, 8'h00);
    mw(255, 8'hF0);
    wb(1'b1, `OCMI_OFF_FSR0, 32'h0000FFFF);
    op(3'h4, 1'b0, 1'b0, 2'h0, 1'b0, 7'd0, 6'h00);
    rdc(`OCMI_OFF_FSR0, 32'h00000000);
    stc(1'b1, 1'b1);
    op(3'h4, 1'b0, 1'b0, 2'h1, 1'b0, 7'd0, 6'h00);
    rdc(`OCMI_OFF_FSR0, 32'h0000FFFF);
    wc(8'hF0);
    // Indirect windows reach memory through the pointers
    wb(1'b1, `OCMI_OFF_FSR0, 32'h00000040);
    mw(64, 8'h00);
    wb(1'b1, `OCMI_OFF_W, 32'h00000012);
    op(3'h0, 1'b1, 1'b0, 2'h0, 1'b0, 7'd0, 6'h00);
    mc(64, 8'h12);
    rdc(`OCMI_OFF_FSR0, 32'h00000040);
    mw(80, 8'h9D);
    op(3'h3, 1'b0, 1'b0, 2'h0, 1'b0, 7'd1, 6'h00);
    wc(8'h9D);
    // Unknown opcode leaves W alone
    op(3'h5, 1'b0, 1'b0, 2'h0, 1'b0, 7'd25, 6'h00);
    wc(8'h9D);
    rdc(`OCMI_OFF_CMD, 32'h00001905);
    // Clock enable low freezes the unit and holds back the answer
    @(posedge core_clk_i);
    ce_i   <= 1'b0;
    wb_req <= '{1'b1, 1'b1, 1'b1, `OCMI_OFF_W, 4'hF, 32'h00000077};
    repeat (4) @(posedge core_clk_i);
    check({24'h000000, w}, 32'h0000009D);
    check({31'h0, wb_ack}, 32'h00000000);
    ce_i <= 1'b1;
    do @(posedge core_clk_i);
    while (wb_ack !== 1'b1);
    wb_req <= '0;
    wc(8'h77);
    finish_test();
  end
endmodule

bind ocmi_core ocmi_core_sva u_sva
(
  .core_clk_i (core_clk_i),
  .rst_b_i    (rst_b_i),
  .ce_i       (ce_i),
  .wb_req_i   (wb_req_i),
  .wb_ack_o   (wb_ack_o),
  .wb_dat_o   (wb_dat_o),
  .w_o        (w_o),
  .flags_o    (flags_o)
);

/* File: test/ocmi_core_sva.sv */
// Port-level checker of the operation unit.
// Assumes a master that holds each request until it samples ack.
`timescale 1ns/1ps
`include "ocmi_map.svh"

module ocmi_core_sva
(
  // Clock, reset, enable
  input wire logic                      core_clk_i,
  input wire logic                      rst_b_i,
  input wire logic                      ce_i,
  // Bus and state
  input wire ocmi_pkg::ocmi_wb_req_type wb_req_i,
  input wire logic                      wb_ack_o,
  input wire logic [31:0]               wb_dat_o,
  input wire logic [7:0]                w_o,
  input wire ocmi_pkg::ocmi_flags_type  flags_o
);
  import ocmi_pkg::*;
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i || !ce_i);

  // ==========================================================================
  // Request decode
  wire       req    = wb_req_i.cyc && wb_req_i.stb;
  wire       wr     = req && wb_req_i.we && wb_req_i.sel[0];
  wire       rd     = wb_ack_o && !wb_req_i.we;
  wire [2:0] op     = wb_req_i.dat[2:0];
  wire       wr_cmd = wr && (wb_req_i.adr == `OCMI_OFF_CMD);
  wire       wr_w   = wr && (wb_req_i.adr == `OCMI_OFF_W);
  wire       wr_st  = wr && (wb_req_i.adr == `OCMI_OFF_STATUS);
  wire       to_w   = wr_cmd && (op <= 3'h4) && (!wb_req_i.dat[3] || op == 3'h4);

  // ==========================================================================
  // Bus handshake
  chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
  chk_ack_req: assert property (wb_ack_o |-> $past(req)) else $error("ack without request");
  chk_ack_bound: assert property ($rose(wb_req_i.stb) |-> ##[1:3] wb_ack_o) else $error("ack too late");
  chk_w_read: assert property (rd && wb_req_i.adr == `OCMI_OFF_W |-> wb_dat_o == {24'h000000, w_o})
    else $error("W read mismatch");
  chk_status_read: assert property (rd && wb_req_i.adr == `OCMI_OFF_STATUS |->
    wb_dat_o == {30'h0, flags_o.zero, flags_o.carry}) else $error("status read mismatch");
  chk_unmapped_read: assert property (rd && wb_req_i.adr == 12'h020 |-> wb_dat_o == 32'h00000000)
    else $error("unmapped read not zero");

  // ==========================================================================
  // State changes and their causes
  chk_w_source: assert property ($changed(w_o) |-> $past(wr_w) || $past(wr_cmd))
    else $error("W changed without cause");
  chk_carry_source: assert property ($changed(flags_o.carry) |->
    $past(wr_st) || $past(wr_cmd && (op == 3'h1 || op == 3'h2))) else $error("carry changed without cause");
  chk_zero_source: assert property ($changed(flags_o.zero) |->
    $past(wr_st) || $past(wr_cmd && op <= 3'h4)) else $error("zero changed without cause");
  chk_zero_on_w: assert property (wb_ack_o && to_w |=> flags_o.zero == (w_o == 8'h00))
    else $error("zero flag does not match W");
endmodule

/* File: verilog/ocmi_core.sv */
// Operation unit: OR, logical shifts, move and indirect load on a byte memory.
// Assumes a classic Wishbone master and one clock with a synchronous reset.
//
// Functional notes
// - OR of working accumulator with file register 0..127; result to destination; zero updated.
// - Destination select 0 writes working accumulator, 1 writes the file register.
// - Left shift: bit 7 to carry, bits 6:0 up one, bit 0 cleared.
// - Right shift: bit 7 cleared, bits 7:1 down one, bit 0 to carry.
// - Move copies file register unchanged to destination, updates zero; two-cycle operation (launch read, then execute).
// - Indirect load fills working accumulator through selected pointer, updates zero.
// - Mode 00 pre-increment, 01 pre-decrement, 10 post-increment, 11 post-decrement.
// - Relative form addresses pointer plus signed offset -32..31; pointer unchanged.
// - Indirect windows hold nothing; accesses go to the address in their pointer.
// - Pointers are 16 bits and wrap modulo 65536 on increment and decrement.
//
// Local design decisions: the placing of the registers and the Wishbone register port.
`timescale 1ns/1ps
`include "ocmi_map.svh"

module ocmi_core
#(
  parameter int MEM_AW = 8
)
(
  // Clock, reset, enable
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_b_i,
  input  wire logic                  ce_i,
  // Wishbone slave
  input  wire ocmi_pkg::ocmi_wb_req_type wb_req_i,
  output logic                       wb_ack_o,
  output logic [31:0]                wb_dat_o,
  // Core state
  output logic [7:0]                 w_o,
  output ocmi_pkg::ocmi_flags_type   flags_o
);

  import ocmi_pkg::*;

  // ========================================================================
  // Helpers
  function automatic logic [15:0] sext_ofs(input logic [`OCMI_CMD_OFS_W-1:0] ofs);
    sext_ofs = {{(16-`OCMI_CMD_OFS_W){ofs[`OCMI_CMD_OFS_W-1]}}, ofs};
  endfunction

  // Window redirection for a direct file address
  function automatic logic [15:0] file_ea(input logic [`OCMI_CMD_FA_W-1:0] fa,
                                          input logic [15:0] p0,
                                          input logic [15:0] p1);
    if (fa == `OCMI_WIN0_ADDR)
      file_ea = p0;
    else if (fa == `OCMI_WIN1_ADDR)
      file_ea = p1;
    else
      file_ea = {{(16-`OCMI_CMD_FA_W){1'b0}}, fa};
  endfunction

  function automatic logic op_known(input logic [2:0] op);
    op_known = (op <= OCMI_OP_MOVE_INDIRECT_TO_W);
  endfunction

  // ========================================================================
  // State
  ocmi_state_type state_reg;
  ocmi_state_type state_next;
  logic [31:0]    cmd_reg;
  logic [15:0]    ea_reg;
  logic [7:0]     w_reg;
  logic [7:0]     w_next;
  logic [15:0]    fsr0_reg;
  logic [15:0]    fsr0_next;
  logic [15:0]    fsr1_reg;
  logic [15:0]    fsr1_next;
  ocmi_flags_type flags_reg;
  ocmi_flags_type flags_next;
  logic           ack_reg;
  logic           ack_next;
  logic [31:0]    dat_reg;
  logic [31:0]    dat_next;

  // ========================================================================
  // Bus decode
  wire              bus_req   = wb_req_i.cyc & wb_req_i.stb;
  wire              accept    = bus_req & ~ack_reg & (state_reg == OCMI_S_IDLE);
  wire              is_wr     = accept & wb_req_i.we;
  wire              is_rd     = accept & ~wb_req_i.we;
  wire              lane0     = wb_req_i.sel[0];
  wire              lane1     = wb_req_i.sel[1];
  wire              hit_cmd   = (wb_req_i.adr == `OCMI_OFF_CMD);
  wire              hit_w     = (wb_req_i.adr == `OCMI_OFF_W);
  wire              hit_st    = (wb_req_i.adr == `OCMI_OFF_STATUS);
  wire              hit_f0    = (wb_req_i.adr == `OCMI_OFF_FSR0);
  wire              hit_f1    = (wb_req_i.adr == `OCMI_OFF_FSR1);
  wire              hit_mem   = (wb_req_i.adr[11:10] == `OCMI_MEM_SEL);
  wire [MEM_AW-1:0] bus_idx   = wb_req_i.adr[MEM_AW+1:2];
  wire              cmd_wr    = is_wr & hit_cmd & lane0;
  wire              mem_bwr   = is_wr & hit_mem & lane0;
  wire              mem_brd   = is_rd & hit_mem;

  // ========================================================================
  // Command fields at launch
  wire [31:0]                cmd_in  = wb_req_i.dat;
  wire [2:0]                 op_in   = cmd_in[`OCMI_CMD_OP_LSB +: `OCMI_CMD_OP_W];
  wire                       idx_in  = cmd_in[`OCMI_CMD_IDX];
  wire ocmi_mode_type        mode_in = ocmi_mode_type'(cmd_in[`OCMI_CMD_MODE_LSB +: 2]);
  wire                       rel_in  = cmd_in[`OCMI_CMD_REL];
  wire [`OCMI_CMD_FA_W-1:0]  fa_in   = cmd_in[`OCMI_CMD_FA_LSB +: `OCMI_CMD_FA_W];
  wire [`OCMI_CMD_OFS_W-1:0] ofs_in  = cmd_in[`OCMI_CMD_OFS_LSB +: `OCMI_CMD_OFS_W];
  wire                       launch  = cmd_wr & op_known(op_in);
  wire                       ind_in  = (op_in == OCMI_OP_MOVE_INDIRECT_TO_W);

  // ========================================================================
  // Indirect address generation
  wire [15:0] ptr     = idx_in ? fsr1_reg : fsr0_reg;
  wire [15:0] ptr_inc = ptr + 16'h0001;
  wire [15:0] ptr_dec = ptr - 16'h0001;
  wire [15:0] ptr_rel = ptr + sext_ofs(ofs_in);
  logic [15:0] ind_ea;
  logic [15:0] ptr_new;

  always_comb
  begin
    ind_ea  = ptr;
    ptr_new = ptr;
    if (rel_in)
    begin
      ind_ea  = ptr_rel;
      ptr_new = ptr;
    end
    else
    begin
      case (mode_in)
        OCMI_PM_PREINC:
        begin
          ind_ea  = ptr_inc;
          ptr_new = ptr_inc;
        end
        OCMI_PM_PREDEC:
        begin
          ind_ea  = ptr_dec;
          ptr_new = ptr_dec;
        end
        OCMI_PM_POSTINC:
        begin
          ind_ea  = ptr;
          ptr_new = ptr_inc;
        end
        OCMI_PM_POSTDEC:
        begin
          ind_ea  = ptr;
          ptr_new = ptr_dec;
        end
        default:
        begin
          ind_ea  = ptr;
          ptr_new = ptr;
        end
      endcase
    end
  end

  wire [15:0] launch_ea = ind_in ? ind_ea : file_ea(fa_in, fsr0_reg, fsr1_reg);

  // ========================================================================
  // Execute stage
  wire [2:0]  op_x   = cmd_reg[`OCMI_CMD_OP_LSB +: `OCMI_CMD_OP_W];
  wire        dest_x = cmd_reg[`OCMI_CMD_DEST];
  wire        ind_x  = (op_x == OCMI_OP_MOVE_INDIRECT_TO_W);
  wire        in_x   = (state_reg == OCMI_S_EXEC);
  wire [7:0]  src;
  logic [7:0] res;
  logic       carry_x;

  always_comb
  begin
    res     = src;
    carry_x = flags_reg.carry;
    case (op_x)
      OCMI_OP_OR:
        res = w_reg | src;
      OCMI_OP_LSL:
      begin
        res     = {src[6:0], 1'b0};
        carry_x = src[7];
      end
      OCMI_OP_LSR:
      begin
        res     = {1'b0, src[7:1]};
        carry_x = src[0];
      end
      OCMI_OP_MOV:
        res = src;
      OCMI_OP_MOVE_INDIRECT_TO_W:
        res = src;
      default:
        res = src;
    endcase
  end

  // Writes to the file register go to the memory; windows were resolved at launch
  wire x_to_mem = in_x & ~ind_x & dest_x;
  wire x_to_w   = in_x & (ind_x | ~dest_x);

  // ========================================================================
  // Memory port
  wire              mem_en   = launch | mem_bwr | mem_brd | x_to_mem;
  wire              mem_we   = mem_bwr | x_to_mem;
  wire [MEM_AW-1:0] mem_addr = in_x   ? ea_reg[MEM_AW-1:0] :
                               launch ? launch_ea[MEM_AW-1:0] : bus_idx;
  wire [7:0]        mem_wd   = in_x ? res : wb_req_i.dat[7:0];

  ocmi_mem
  #(
    .DATA_W (8),
    .ADDR_W (MEM_AW)
  )
  u_mem
  (
    .core_clk_i (core_clk_i),
    .rst_b_i    (rst_b_i),
    .ce_i       (ce_i),
    .en_i       (mem_en),
    .we_i       (mem_we),
    .addr_i     (mem_addr),
    .wdata_i    (mem_wd),
    .rdata_o    (src)
  );

  // ========================================================================
  // Register read data
  wire [31:0] rd_w   = {24'h000000, w_reg};
  wire [31:0] rd_st  = {30'h0, flags_reg.zero, flags_reg.carry};
  wire [31:0] rd_f0  = {16'h0000, fsr0_reg};
  wire [31:0] rd_f1  = {16'h0000, fsr1_reg};
  wire [31:0] rd_reg = hit_cmd ? cmd_reg :
                       hit_w   ? rd_w    :
                       hit_st  ? rd_st   :
                       hit_f0  ? rd_f0   :
                       hit_f1  ? rd_f1   : 32'h0000_0000;

  // ========================================================================
  // Next-state logic
  always_comb
  begin
    state_next = state_reg;
    ack_next   = 1'b0;
    dat_next   = dat_reg;
    case (state_reg)
      OCMI_S_IDLE:
      begin
        if (mem_brd)
          state_next = OCMI_S_BUSRD;
        else if (accept)
        begin
          ack_next = 1'b1;
          dat_next = wb_req_i.we ? 32'h0000_0000 : rd_reg;
          if (launch)
          begin
            state_next = OCMI_S_EXEC;
          end
        end
      end
      OCMI_S_EXEC:
        state_next = OCMI_S_IDLE;
      OCMI_S_BUSRD:
      begin
        ack_next   = 1'b1;
        dat_next   = {24'h000000, src};
        state_next = OCMI_S_IDLE;
      end
      default:
        state_next = OCMI_S_IDLE;
    endcase
  end

  always_comb
  begin
    w_next     = w_reg;
    flags_next = flags_reg;
    fsr0_next  = fsr0_reg;
    fsr1_next  = fsr1_reg;
    if (is_wr && hit_w && lane0)
      w_next = wb_req_i.dat[7:0];
    if (is_wr && hit_st && lane0)
    begin
      flags_next.carry = wb_req_i.dat[`OCMI_ST_CARRY];
      flags_next.zero  = wb_req_i.dat[`OCMI_ST_ZERO];
    end
    if (is_wr && hit_f0)
    begin
      fsr0_next[7:0]  = lane0 ? wb_req_i.dat[7:0]  : fsr0_reg[7:0];
      fsr0_next[15:8] = lane1 ? wb_req_i.dat[15:8] : fsr0_reg[15:8];
    end
    if (is_wr && hit_f1)
    begin
      fsr1_next[7:0]  = lane0 ? wb_req_i.dat[7:0]  : fsr1_reg[7:0];
      fsr1_next[15:8] = lane1 ? wb_req_i.dat[15:8] : fsr1_reg[15:8];
    end
    if (launch && ind_in && !idx_in)
      fsr0_next = ptr_new;
    if (launch && ind_in && idx_in)
      fsr1_next = ptr_new;
    if (x_to_w)
      w_next = res;
    if (in_x)
    begin
      flags_next.zero  = (res == 8'h00);
      flags_next.carry = carry_x;
    end
  end

  // ========================================================================
  // Registers
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= OCMI_S_IDLE;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      cmd_reg   <= `OCMI_RST_CMD;
      ea_reg    <= `OCMI_RST_FSR;
    end
    else if (ce_i)
    begin
      state_reg <= state_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      if (cmd_wr)
      begin
        cmd_reg <= cmd_in;
        ea_reg  <= launch_ea;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      w_reg           <= `OCMI_RST_W;
      fsr0_reg        <= `OCMI_RST_FSR;
      fsr1_reg        <= `OCMI_RST_FSR;
      flags_reg.zero  <= `OCMI_RST_FLAG;
      flags_reg.carry <= `OCMI_RST_FLAG;
    end
    else if (ce_i)
    begin
      w_reg     <= w_next;
      fsr0_reg  <= fsr0_next;
      fsr1_reg  <= fsr1_next;
      flags_reg <= flags_next;
    end
  end

  // ========================================================================
  // Outputs
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = dat_reg;
  assign w_o      = w_reg;
  assign flags_o  = flags_reg;

endmodule

/* File: verilog/ocmi_map.svh */
// Address map, field positions and reset values of the operation unit.
// Assumes a 12-bit Wishbone byte address and 32-bit data.
`ifndef OCMI_MAP_SVH
`define OCMI_MAP_SVH

// ==========================================================================
// Register byte offsets
`define OCMI_ADR_W        12
`define OCMI_OFF_CMD      12'h000
`define OCMI_OFF_W        12'h004
`define OCMI_OFF_STATUS   12'h008
`define OCMI_OFF_FSR0     12'h00C
`define OCMI_OFF_FSR1     12'h010
// Data memory window: adr[11:10] == 2'b01, one byte per word
`define OCMI_MEM_SEL      2'h1

// ==========================================================================
// Command word fields
`define OCMI_CMD_OP_LSB   0
`define OCMI_CMD_OP_W     3
`define OCMI_CMD_DEST     3
`define OCMI_CMD_IDX      4
`define OCMI_CMD_MODE_LSB 5
`define OCMI_CMD_REL      7
`define OCMI_CMD_FA_LSB   8
`define OCMI_CMD_FA_W     7
`define OCMI_CMD_OFS_LSB  16
`define OCMI_CMD_OFS_W    6

// ==========================================================================
// Status fields and file addresses of the indirect windows
`define OCMI_ST_CARRY     0
`define OCMI_ST_ZERO      1
`define OCMI_WIN0_ADDR    7'h00
`define OCMI_WIN1_ADDR    7'h01

// ==========================================================================
// Reset values
`define OCMI_RST_CMD      32'h0000_0000
`define OCMI_RST_W        8'h00
`define OCMI_RST_FSR      16'h0000
`define OCMI_RST_FLAG     1'b0

`endif

/* File: verilog/ocmi_mem.sv */
// Single-port data memory of the operation unit with registered read data.
// Assumes one access per cycle, chosen by the controller.
`timescale 1ns/1ps

module ocmi_mem
#(
  parameter int DATA_W = 8,
  parameter int ADDR_W = 8
)
(
  // Clock and control
  input  wire logic              core_clk_i,
  input  wire logic              rst_b_i,
  input  wire logic              ce_i,
  // Access port
  input  wire logic              en_i,
  input  wire logic              we_i,
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  output logic      [DATA_W-1:0] rdata_o
);

  // ========================================================================
  // Storage
  logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

  always_ff @(posedge core_clk_i)
  begin
    if (ce_i && en_i && we_i)
    begin
      mem_reg[addr_i] <= wdata_i;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      rdata_o <= '0;
    end
    else if (ce_i && en_i && !we_i)
    begin
      rdata_o <= mem_reg[addr_i];
    end
  end

endmodule

/* File: verilog/ocmi_pkg.sv */
// Types shared by the operation unit, its checker and its testbench.
// Assumes ocmi_map.svh sits on the include path.
`include "ocmi_map.svh"

package ocmi_pkg;

  // ========================================================================
  // Operations
  typedef enum logic [2:0] {
    OCMI_OP_OR    = 3'h0,
    OCMI_OP_LSL   = 3'h1,
    OCMI_OP_LSR   = 3'h2,
    OCMI_OP_MOV   = 3'h3,
    OCMI_OP_MOVE_INDIRECT_TO_W = 3'h4
  } ocmi_op_type;

  // Pointer modes
  typedef enum logic [1:0] {
    OCMI_PM_PREINC  = 2'h0,
    OCMI_PM_PREDEC  = 2'h1,
    OCMI_PM_POSTINC = 2'h2,
    OCMI_PM_POSTDEC = 2'h3
  } ocmi_mode_type;

  // Controller states
  typedef enum logic [1:0] {
    OCMI_S_IDLE  = 2'h0,
    OCMI_S_EXEC  = 2'h1,
    OCMI_S_BUSRD = 2'h2
  } ocmi_state_type;

  // ========================================================================
  // Wishbone request bundle
  typedef struct packed {
    logic                   cyc;
    logic                   stb;
    logic                   we;
    logic [`OCMI_ADR_W-1:0] adr;
    logic [3:0]             sel;
    logic [31:0]            dat;
  } ocmi_wb_req_type;

  // ALU flags
  typedef struct packed {
    logic zero;
    logic carry;
  } ocmi_flags_type;

endpackage
